// [pag_port_a_gpio.sv]
// Five-pin general purpose port with latch, direction and analog select
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pag_port_a_gpio (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_out,
  output logic [3:0] analog_select_out,
  output logic timer_external_clock_out
);

  logic [4:0] port_pin_data;
  logic [4:0] port_pin_direction;
  logic [3:0] analog_pin_config;
  logic [4:0] pin_read;
  logic [4:0] next_port_pin_data;
  logic [4:0] next_pin_oe;
  logic [4:0] next_pin_drive;
  logic [7:0] next_rdata;
  logic wr_data;
  logic wr_dir;
  logic wr_ana;
  logic wr_set;
  logic wr_clr;

  assign wr_data = wr_in && (addr_in == pag_pkg::OFS_PIN_DATA);
  assign wr_dir = wr_in && (addr_in == pag_pkg::OFS_PIN_DIRECTION);
  assign wr_ana = wr_in && (addr_in == pag_pkg::OFS_ANALOG_PIN_CONFIG);
  assign wr_set = wr_in && (addr_in == pag_pkg::OFS_PIN_SET);
  assign wr_clr = wr_in && (addr_in == pag_pkg::OFS_PIN_CLEAR);

  // Digital view of the pins; analog pins read zero
  always_comb begin
    pin_read[4] = pin_in[4];
    pin_read[3:0] = pin_in[3:0] & ~analog_pin_config;
  end

  // Latch update; sampled pins are the starting point of any modify
  always_comb begin
    next_port_pin_data = port_pin_data;
    if (wr_data) begin
      next_port_pin_data = wdata_in[4:0];
    end else if (wr_set) begin
      next_port_pin_data = pin_read | wdata_in[4:0];
    end else if (wr_clr) begin
      next_port_pin_data = pin_read & ~wdata_in[4:0];
    end
  end

  // Latch written regardless of direction
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      port_pin_data <= pag_pkg::RST_PIN_DATA;
    end else begin
      port_pin_data <= next_port_pin_data;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      port_pin_direction <= pag_pkg::RST_PIN_DIRECTION;
    end else if (wr_dir) begin
      port_pin_direction <= wdata_in[4:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      analog_pin_config <= pag_pkg::RST_ANALOG_PIN_CONFIG;
    end else if (wr_ana) begin
      analog_pin_config <= wdata_in[3:0];
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_in)
      pag_pkg::OFS_PIN_DATA: begin
        next_rdata = {3'h0, pin_read};
      end
      pag_pkg::OFS_PIN_DIRECTION: begin
        next_rdata = {3'h0, port_pin_direction};
      end
      pag_pkg::OFS_ANALOG_PIN_CONFIG: begin
        next_rdata = {4'h0, analog_pin_config};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_out <= pag_pkg::RST_READ_DATA;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= pag_pkg::RST_READ_DATA;
    end
  end

  // Drivers; analog selection does not override direction
  always_comb begin
    next_pin_oe[3:0] = ~port_pin_direction[3:0];
    // Open drain: enable only when driving a low
    next_pin_oe[4] = ~port_pin_direction[4] & ~port_pin_data[4];
    // Pin four never drives high, so its drive bit is held at zero
    next_pin_drive = {1'b0, port_pin_data[3:0]};
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_oe_out <= pag_pkg::RST_PIN_OE;
    end else begin
      pin_oe_out <= next_pin_oe;
    end
  end

  // Drive value of pins 0 to 3 follows the latch even while the driver is off
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_out <= pag_pkg::RST_PIN_DRIVE;
    end else begin
      pin_out <= next_pin_drive;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      analog_select_out <= pag_pkg::RST_ANALOG_PIN_CONFIG;
    end else begin
      analog_select_out <= analog_pin_config;
    end
  end

  // Hysteresis is in the pad; the timer sees the raw level
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      timer_external_clock_out <= pag_pkg::RST_TIMER_CLOCK;
    end else begin
      timer_external_clock_out <= pin_in[pag_pkg::PIN4_IDX];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_latch_full_write: assert property (
    wr_data |=> port_pin_data == $past(wdata_in[4:0]))
    else $error("latch did not take written value");

  chk_input_driver_off: assert property (
    port_pin_direction[3:0] == 4'hf ##1 port_pin_direction[3:0] == 4'hf
      |=> pin_oe_out[3:0] == 4'h0)
    else $error("driver enabled on input pin");

  chk_output_drives_latch: assert property (
    1'b1 |=> (pin_oe_out[3:0] == ~$past(port_pin_direction[3:0]))
      && (pin_out[3:0] == $past(port_pin_data[3:0])))
    else $error("pin drive does not follow latch and direction");

  chk_read_pin_levels: assert property (
    rd_in && addr_in == pag_pkg::OFS_PIN_DATA |=> rdata_out[4:0] == $past(pin_read))
    else $error("data read did not return pin levels");

  chk_set_is_rmw: assert property (
    wr_set |=> port_pin_data == ($past(pin_read) | $past(wdata_in[4:0])))
    else $error("set write not read-modify-write");

  chk_clear_is_rmw: assert property (
    wr_clr |=> port_pin_data == ($past(pin_read) & ~$past(wdata_in[4:0])))
    else $error("clear write not read-modify-write");

  chk_open_drain_pin: assert property (
    1'b1 |=> !pin_out[4]
      && pin_oe_out[4] == (!$past(port_pin_direction[4]) && !$past(port_pin_data[4])))
    else $error("pin four not open drain");

  chk_timer_clock_route: assert property (
    1'b1 |=> timer_external_clock_out == $past(pin_in[4]))
    else $error("timer clock not following pin four");

  chk_analog_reads_zero: assert property (
    rd_in && addr_in == pag_pkg::OFS_PIN_DATA
      |=> (rdata_out[3:0] & $past(analog_pin_config)) == 4'h0)
    else $error("analog pin read nonzero");

  // Own disable, since the default one would mask every reset check
  chk_reset_analog: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    rst_in |=> analog_pin_config == 4'hf && analog_select_out == 4'hf)
    else $error("pins not analog after reset");

  chk_analog_drive_kept: assert property (
    analog_pin_config != 4'h0 |=> (pin_oe_out[3:0] & $past(analog_pin_config))
      == (~$past(port_pin_direction[3:0]) & $past(analog_pin_config)))
    else $error("analog select disabled driver");

  chk_dir_keeps_latch: assert property (
    wr_dir |=> $stable(port_pin_data))
    else $error("direction write altered latch");

  chk_reset_direction: assert property (disable iff (1'b0)
    rst_in |=> port_pin_direction == pag_pkg::RST_PIN_DIRECTION
      && pin_oe_out == pag_pkg::RST_PIN_OE)
    else $error("direction not input after reset");

  chk_reset_latch: assert property (disable iff (1'b0)
    rst_in |=> port_pin_data == pag_pkg::RST_PIN_DATA
      && pin_out == pag_pkg::RST_PIN_DRIVE)
    else $error("latch or drive not cleared by reset");

  chk_reset_read_zero: assert property (disable iff (1'b0)
    rst_in |=> rdata_out == pag_pkg::RST_READ_DATA
      && timer_external_clock_out == pag_pkg::RST_TIMER_CLOCK)
    else $error("read data or timer clock not cleared by reset");

  chk_read_dir_value: assert property (
    rd_in && addr_in == pag_pkg::OFS_PIN_DIRECTION
      |=> rdata_out == {3'h0, $past(port_pin_direction)})
    else $error("direction read wrong");

  chk_read_ana_value: assert property (
    rd_in && addr_in == pag_pkg::OFS_ANALOG_PIN_CONFIG
      |=> rdata_out == {4'h0, $past(analog_pin_config)})
    else $error("analog config read wrong");

  chk_read_idle_zero: assert property (
    !rd_in |=> rdata_out == pag_pkg::RST_READ_DATA)
    else $error("read data not zero outside read");

  chk_read_unmapped: assert property (
    rd_in && addr_in > pag_pkg::OFS_ANALOG_PIN_CONFIG
      |=> rdata_out == pag_pkg::RST_READ_DATA)
    else $error("unmapped or write-only read not zero");

  chk_read_pin4_level: assert property (
    rd_in && addr_in == pag_pkg::OFS_PIN_DATA
      |=> rdata_out[pag_pkg::PIN4_IDX] == $past(pin_in[pag_pkg::PIN4_IDX]))
    else $error("pin four read not its level");

  chk_read_digital_level: assert property (
    rd_in && addr_in == pag_pkg::OFS_PIN_DATA
      |=> rdata_out[3:0] == ($past(pin_in[3:0]) & ~$past(analog_pin_config)))
    else $error("digital pin read not its level");

  chk_dir_write_lands: assert property (
    wr_dir |=> port_pin_direction == $past(wdata_in[4:0]))
    else $error("direction write lost");

  chk_ana_write_lands: assert property (
    wr_ana |=> analog_pin_config == $past(wdata_in[3:0]))
    else $error("analog config write lost");

  chk_latch_holds: assert property (
    !(wr_data || wr_set || wr_clr) |=> $stable(port_pin_data))
    else $error("latch changed without a write");

  chk_ana_keeps_port: assert property (
    wr_ana |=> $stable(port_pin_data) && $stable(port_pin_direction))
    else $error("analog config write altered port");

  chk_dir_keeps_analog: assert property (
    wr_dir |=> $stable(analog_pin_config))
    else $error("direction write altered analog config");

  chk_select_copy: assert property (
    1'b1 |=> analog_select_out == $past(analog_pin_config))
    else $error("analog select not following config");

  chk_pin4_never_high: assert property (
    pin_out[pag_pkg::PIN4_IDX] == 1'b0)
    else $error("pin four driven high");

  chk_pin4_release: assert property (
    port_pin_direction[pag_pkg::PIN4_IDX] |=> !pin_oe_out[pag_pkg::PIN4_IDX])
    else $error("pin four driven while input");

  chk_pin4_high_floats: assert property (
    port_pin_data[pag_pkg::PIN4_IDX] |=> !pin_oe_out[pag_pkg::PIN4_IDX])
    else $error("pin four driven for a high");

  // Unwritten bits come from the pins, so an input bit may pick up its level
  chk_set_from_pins: assert property (
    wr_set |=> (port_pin_data & ~$past(wdata_in[4:0]))
      == ($past(pin_in) & {1'b1, ~$past(analog_pin_config)} & ~$past(wdata_in[4:0])))
    else $error("set write not seeded from pins");

  chk_set_keeps_ones: assert property (
    wr_set |=> (port_pin_data & $past(wdata_in[4:0])) == $past(wdata_in[4:0]))
    else $error("set write missed a bit");

  chk_clear_from_pins: assert property (
    wr_clr |=> (port_pin_data & ~$past(wdata_in[4:0]))
      == ($past(pin_in) & {1'b1, ~$past(analog_pin_config)} & ~$past(wdata_in[4:0])))
    else $error("clear write not seeded from pins");

  chk_clear_sets_none: assert property (
    wr_clr |=> (port_pin_data & $past(wdata_in[4:0])) == 5'h00)
    else $error("clear write left a bit set");

  chk_write_ignores_dir: assert property (
    wr_data && port_pin_direction == 5'h1f |=> port_pin_data == $past(wdata_in[4:0]))
    else $error("latch refused write while input");

  chk_oe_after_dir_write: assert property (
    $changed(pin_oe_out[3:0]) |-> $past(wr_dir, 2))
    else $error("driver changed without direction write");

  chk_drive_after_latch: assert property (
    $changed(pin_out) |-> $past(wr_data, 2) || $past(wr_set, 2) || $past(wr_clr, 2))
    else $error("drive value changed without latch write");

  // One driver check per analog-capable pin
  for (genvar p = 0; p < pag_pkg::ANA_W; p++) begin : g_pin_drv
    chk_pin_follows_dir: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> pin_oe_out[p] == !$past(port_pin_direction[p]))
      else $error("pin driver not following its direction bit");
  end

  cov_read_data: cover property (rd_in && addr_in == pag_pkg::OFS_PIN_DATA);
  cov_set_write: cover property (wr_set ##1 wr_dir);
  cov_pin4_low_drive: cover property (pin_oe_out[4] ##1 !pin_oe_out[4]);
  cov_digital_switch: cover property (wr_ana ##1 analog_pin_config == 4'h0);
  cov_timer_edge: cover property (!timer_external_clock_out ##1 timer_external_clock_out);

endmodule : pag_port_a_gpio
`default_nettype wire

// [pag_pkg.sv]
// Shared constants for the five-pin general purpose port
package pag_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_W = 5;
  localparam int ANA_W = 4;
  localparam int PIN4_IDX = 4;
  // Register offsets
  localparam logic [3:0] OFS_PIN_DATA = 4'h0;
  localparam logic [3:0] OFS_PIN_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_ANALOG_PIN_CONFIG = 4'h2;
  localparam logic [3:0] OFS_PIN_SET = 4'h3;
  localparam logic [3:0] OFS_PIN_CLEAR = 4'h4;
  // Values after reset
  localparam logic [4:0] RST_PIN_DATA = 5'h00;
  localparam logic [4:0] RST_PIN_DIRECTION = 5'h1f;
  localparam logic [3:0] RST_ANALOG_PIN_CONFIG = 4'hf;
  localparam logic [7:0] RST_READ_DATA = 8'h00;
  localparam logic [4:0] RST_PIN_OE = 5'h00;
  localparam logic [4:0] RST_PIN_DRIVE = 5'h00;
  localparam logic RST_TIMER_CLOCK = 1'b0;
endpackage : pag_pkg

// [pag_pin_model.sv]
// Board model of the five port pins: pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none
module pag_pin_model (
  input wire logic [4:0] drv_in,
  input wire logic [4:0] oe_in,
  input wire logic [4:0] ext_in,
  input wire logic [4:0] ext_en_in,
  output logic [4:0] level_out
);
  // Pull-up keeps pins driven by neither the port nor the board at one, never a stale level
  always_comb begin
    level_out = (ext_en_in & ext_in) | ~ext_en_in;
    level_out = (oe_in & drv_in) | (~oe_in & level_out);
  end
endmodule // pag_pin_model
`default_nettype wire

// [pag_port_a_gpio_tb_top.sv]
// Self-checking testbench for the five-pin port
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pag_port_a_gpio_tb_top;
  logic clk = 0, rst = 1, wr = 0, rd = 0, tclk;
  logic [3:0] addr = 4'h0, asel;
  logic [7:0] wd = 8'h00, rdat, got;
  logic [4:0] pin, pout, poe, ext = 5'h00, ext_en = 5'h00;
  int miscompares = 0, n_checks = 0;
  always #4 clk = ~clk;
  pag_port_a_gpio dut (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wd),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .pin_in(pin), .pin_out(pout), .pin_oe_out(poe),
    .analog_select_out(asel), .timer_external_clock_out(tclk));
  pag_pin_model pads (.drv_in(pout), .oe_in(poe), .ext_in(ext), .ext_en_in(ext_en),
    .level_out(pin));
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Pin outputs trail the register by one cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic board(input logic [4:0] en, input logic [4:0] v);
    @(posedge clk);
    ext_en <= en;
    ext <= v;
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    rd_reg(4'h0, got);
    `CK("pins after reset", 8'h10, got)
    rd_reg(4'h1, got);
    `CK("direction", 8'h1f, got)
    `CK("oe after reset", 5'h00, poe)
    `CK("analog select", 4'hf, asel)
    rd_reg(4'h5, got);
    `CK("unmapped read", 8'h00, got)
  endtask
  task automatic t_drive;
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h0, 8'h15);
    settle;
    `CK("oe while input", 5'h00, poe)
    `CK("analog select digital", 4'h0, asel)
    wr_reg(4'h1, 8'h00);
    settle;
    `CK("latched drive", 5'h05, pout)
    `CK("oe pin4 open drain", 5'h0f, poe)
    wr_reg(4'h1, 8'h1f);
    board(5'h1f, 5'h0a);
    rd_reg(4'h0, got);
    `CK("pin levels read", 8'h0a, got)
  endtask
  task automatic t_rmw;
    wr_reg(4'h3, 8'h01);
    board(5'h00, 5'h00);
    wr_reg(4'h1, 8'h00);
    settle;
    `CK("set from pins", 5'h0b, pout)
    `CK("pin4 pulls low", 5'h1f, poe)
    wr_reg(4'h4, 8'h02);
    settle;
    `CK("clear from pins", 5'h09, pout)
  endtask
  task automatic t_timer;
    // Analog pins keep direction set, drivers off
    wr_reg(4'h1, 8'h1f);
    for (int i = 0; i < 2; i++) begin
      board(5'h10, {~i[0], 4'h0});
      @(posedge clk);
      #1 `CK("timer clock", ~i[0], tclk)
    end
    wr_reg(4'h2, 8'h0f);
    board(5'h1f, 5'h1f);
    rd_reg(4'h0, got);
    `CK("analog reads zero", 8'h10, got)
    `CK("oe while analog", 5'h00, poe)
    rd_reg(4'h2, got);
    `CK("analog config read", 8'h0f, got)
    `CK("analog select restored", 4'hf, asel)
    rd_reg(4'h3, got);
    `CK("set offset read", 8'h00, got)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_drive;
    t_rmw;
    t_timer;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule // pag_port_a_gpio_tb_top
`default_nettype wire
